/* File: common/vec_defs.svh */
// Purpose: Constants of the echo canceller datapath.
// Assumes: Included by its bare name.
// Notes: Widths and counts match the sample processing sequence.
`ifndef VEC_DEFS_SVH
`define VEC_DEFS_SVH
`define VEC_TAPS 128
`define VEC_LINE_LEN 144
`define VEC_UN_LEN 16
`define VEC_HANG_LEN 10'd600
`define VEC_HPF_SHIFT 3
`define VEC_HALF_SHIFT 15
`define VEC_HALFG_SHIFT 12
`define VEC_AVG_SHIFT 9
`define VEC_SUPP_SHIFT 4
`define VEC_CUTOFF 16'h0080
`define VEC_TABLE_BASE 8'h00
`define VEC_ECHO_ESTIMATE_LSB 15
`define VEC_RECIP_NUM 16'h8000
`define VEC_DIV_STEPS 5'd15
`define VEC_Q15_MAX 16'h7fff
`define VEC_MU_CLIP 17'h01fde
`define VEC_MU_BIAS 14'h0021
`define VEC_A_CLIP 17'h00fff
`define VEC_A_XOR 8'h55
`endif

/* File: common/vec_pkg.sv */
// Purpose: Types of the echo canceller datapath.
// Assumes: Nothing beyond the constants header.
// Notes: The sequence states follow the order of processing.
package vec_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_EXPAND, ST_HPF, ST_MAC, ST_ESTIMATE, ST_OUTPUT,
    ST_COMPRESS, ST_AVERAGE, ST_RECIP, ST_NORM, ST_FINISH
  } vec_fsm_e;
  typedef logic [7:0] vec_code_t;
endpackage

/* File: verilog/vec_codec.sv */
// Purpose: Companding expansion table and linear to code compression.
// Assumes: Purely combinational; the caller registers the results.
// Notes: The law is fixed when the design is built.
`timescale 1ns/1ps
`include "vec_defs.svh"
module vec_codec #(
  parameter bit ALAW = 1'b0
) (
  input  wire vec_pkg::vec_code_t code_in,
  input  wire logic [15:0]        linear_in,
  output logic [13:0]             linear_out,
  output vec_pkg::vec_code_t      code_out
);
  import vec_pkg::*;
  logic [13:0] expand_table [0:255];
  function automatic logic [13:0] expand(input logic [7:0] code);
    logic [7:0]  c;
    logic [13:0] mag;
    c = ALAW ? (code ^ `VEC_A_XOR) : ~code;
    if (ALAW) begin
      if (c[6:4] == 3'h0) mag = {9'h0, c[3:0], 1'b1};
      else mag = ({9'h0, c[3:0], 1'b0} + 14'h0021) << (c[6:4] - 3'h1);
      expand = c[7] ? mag : 14'(-mag);
    end else begin
      mag = (({9'h0, c[3:0], 1'b0} + `VEC_MU_BIAS) << c[6:4]) - `VEC_MU_BIAS;
      expand = c[7] ? 14'(-mag) : mag;
    end
  endfunction
  always_comb begin
    for (int i = 0; i < 256; i++) begin
      expand_table[i] = expand(8'(i));
    end
  end
  assign linear_out = expand_table[8'(`VEC_TABLE_BASE + code_in)];
  always_comb begin
    logic        neg;
    logic [16:0] a;
    logic [13:0] b;
    logic [2:0]  e;
    logic [13:0] m;
    b = 14'h0000;
    m = 14'h0000;
    neg = linear_in[15];
    a = neg ? 17'(-{linear_in[15], linear_in}) : {1'b0, linear_in};
    e = 3'h0;
    if (ALAW) begin
      if (a > `VEC_A_CLIP) a = `VEC_A_CLIP;
      for (int i = 1; i < 8; i++) begin
        if (a[i+4]) e = 3'(i);
      end
      b = a[13:0];
      m = (e == 3'h0) ? (b >> 1) : (b >> e);
      code_out = {~neg, e, m[3:0]} ^ `VEC_A_XOR;
    end else begin
      if (a > `VEC_MU_CLIP) a = `VEC_MU_CLIP;
      b = a[13:0] + `VEC_MU_BIAS;
      for (int i = 0; i < 8; i++) begin
        if (b[i+5]) e = 3'(i);
      end
      m = b >> (e + 3'h1);
      code_out = {~neg, ~e, ~m[3:0]};
    end
  end
endmodule

/* File: verilog/vec_datapath.sv */
// Purpose: Per-sample datapath of a 128-tap voice echo canceller.
// Assumes: Marks and codes come from pins; detector and updater share ref_clk.
// Notes: One sequence runs per output mark and then waits for the next.
`timescale 1ns/1ps
`include "vec_defs.svh"
// Functional notes
// - One processing sequence per 125 us output mark.
// - Input mark captures samples without disturbing processing.
// - Skip coefficient update during near-end activity.
// - Mu-law or A-law chosen at build time.
// - Expansion by 256-entry 14-bit table, code plus base.
// - Newest reference expanded into line, absolute kept.
// - First-order DC-blocking high-pass, g is 2^-3.
// - High-pass state kept as high and low words.
// - Echo estimate sums 128 taps; line shifts each period.
// - Line extends to 143 old samples, outside convolution.
// - Tap coefficients cleared to zero at reset.
// - Coefficients Q15, samples and estimate 16-bit integers.
// - Estimate taken from accumulator bits 30 to 15.
// - Output is filtered near-end minus echo estimate.
// - Zero output when output average below reference/16.
// - No suppression while hangover count is nonzero.
// - Compress output to selected code each period.
// - Output average one-pole low-pass, coefficient 2^-7.
// - Average step uses 2^16 and 2^9 scaled terms.
// - Reference average adds a 2^9 scaled cutoff term.
// - Reciprocal by conditional subtraction, Q15 positive fraction.
// - Normalized output is output times reference reciprocal.
// - Keep 16 normalized outputs, shift older by one.
// - Saturate normalized output to the Q15 range.
// - Hangover loads 600 on speech, else counts down.
module vec_datapath #(
  parameter int          TAPS     = `VEC_TAPS,
  parameter int          LINE_LEN = `VEC_LINE_LEN,
  parameter int          UN_LEN   = `VEC_UN_LEN,
  parameter logic [9:0]  HANG_LEN = `VEC_HANG_LEN,
  parameter logic [15:0] CUTOFF   = `VEC_CUTOFF,
  parameter bit          ALAW     = 1'b0
) (
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire logic               out_mark,
  input  wire logic               in_mark,
  input  wire vec_pkg::vec_code_t ref_code_pin,
  input  wire vec_pkg::vec_code_t near_code_pin,
  input  wire logic               near_speech_detect,
  input  wire logic               coeff_wr_en,
  input  wire logic [6:0]         coeff_wr_idx,
  input  wire logic [15:0]        coeff_wr_data,
  input  wire logic [3:0]         hist_rd_idx,
  input  wire logic [7:0]         ref_rd_idx,
  output vec_pkg::vec_code_t      tx_code,
  output logic                    tx_valid,
  output logic                    busy,
  output logic                    adapt_enable,
  output logic [15:0]             ref_newest_sample,
  output logic [15:0]             ref_abs_sample,
  output logic [15:0]             echo_estimate,
  output logic [15:0]             cancel_output,
  output logic [15:0]             output_mag_average,
  output logic [15:0]             ref_mag_average,
  output logic [15:0]             ref_average_reciprocal,
  output logic [15:0]             normalized_error_newest,
  output logic [9:0]              hangover_counter,
  output logic [15:0]             hist_rd_data,
  output logic [15:0]             ref_rd_data
);
  import vec_pkg::*;

  typedef struct packed {
    logic [2:0]                   out_s;
    logic [2:0]                   in_s;
    logic [7:0]                   ref_s1;
    logic [7:0]                   ref_s2;
    logic [7:0]                   near_s1;
    logic [7:0]                   near_s2;
    logic [7:0]                   ref_input_slot;
    logic [7:0]                   near_slot;
    vec_fsm_e                     state;
    logic [LINE_LEN-1:0][15:0]    line;
    logic [TAPS-1:0][15:0]        coeff;
    logic [UN_LEN-1:0][15:0]      un_hist;
    logic [15:0]                  ref_abs_sample;
    logic [15:0]                  nearend_raw_linear;
    logic [15:0]                  raw_prev;
    logic [15:0]                  nearend_filtered_msw;
    logic [15:0]                  nearend_filtered_lsw;
    logic [39:0]                  acc;
    logic [7:0]                   tap;
    logic [15:0]                  echo_estimate;
    logic [15:0]                  cancel_out;
    logic [7:0]                   tx_code;
    logic                         tx_valid;
    logic [15:0]                  output_mag_average;
    logic [15:0]                  ref_mag_average;
    logic [15:0]                  recip;
    logic [16:0]                  rem;
    logic [4:0]                   bitcnt;
    logic [9:0]                   hangover_counter;
    logic                         adapt_enable;
    logic                         busy;
    logic [15:0]                  hist_rd_data;
    logic [15:0]                  ref_rd_data;
  } vec_regs_s;

  vec_regs_s   state_reg;
  vec_regs_s   state_next;
  logic [13:0] lin_value;
  logic [7:0]  comp_code;
  logic [7:0]  expand_code;
  logic        out_rise;
  logic        in_rise;

  function automatic logic [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sh0000007fff) sat16 = 16'h7fff;
    else if (v < -40'sh0000008000) sat16 = 16'h8000;
    else sat16 = v[15:0];
  endfunction

  function automatic logic [15:0] abs16(input logic [15:0] v);
    if (v == 16'h8000) abs16 = 16'h7fff;
    else abs16 = v[15] ? 16'(-v) : v;
  endfunction

  function automatic logic [15:0] avg_step(input logic [15:0] avg,
                                           input logic [15:0] x,
                                           input logic [15:0] extra);
    logic [33:0] e;
    e = (34'(avg) << 16) - (34'(avg) << `VEC_AVG_SHIFT)
      + (34'(x) << `VEC_AVG_SHIFT) + (34'(extra) << `VEC_AVG_SHIFT);
    avg_step = e[31:16];
  endfunction

  assign out_rise    = state_reg.out_s[1] & ~state_reg.out_s[2];
  assign in_rise     = state_reg.in_s[1] & ~state_reg.in_s[2];
  assign expand_code = (state_reg.state == ST_HPF) ? state_reg.near_slot
                                                   : state_reg.ref_input_slot;

  vec_codec #(
    .ALAW (ALAW)
  ) u_codec (
    .code_in    (expand_code),
    .linear_in  (state_reg.cancel_out),
    .linear_out (lin_value),
    .code_out   (comp_code)
  );

  always_comb begin
    logic signed [39:0] s40;
    logic signed [39:0] d40;
    logic signed [39:0] w;
    logic [15:0]        u;
    logic [16:0]        t;
    logic [15:0]        q;
    logic signed [31:0] prod;
    logic signed [31:0] mac;
    logic [15:0]        num;
    s40 = '0;
    d40 = '0;
    w = '0;
    u = '0;
    t = '0;
    q = '0;
    prod = '0;
    mac = '0;
    num = `VEC_RECIP_NUM;
    state_next = state_reg;
    state_next.out_s = {state_reg.out_s[1:0], out_mark};
    state_next.in_s = {state_reg.in_s[1:0], in_mark};
    state_next.ref_s1 = ref_code_pin;
    state_next.ref_s2 = state_reg.ref_s1;
    state_next.near_s1 = near_code_pin;
    state_next.near_s2 = state_reg.near_s1;
    state_next.tx_valid = 1'b0;
    state_next.hist_rd_data = state_reg.un_hist[hist_rd_idx];
    if (int'(ref_rd_idx) < LINE_LEN) begin
      state_next.ref_rd_data = state_reg.line[ref_rd_idx];
    end else begin
      state_next.ref_rd_data = 16'h0000;
    end
    if (in_rise) begin
      state_next.ref_input_slot = state_reg.ref_s2;
      state_next.near_slot = state_reg.near_s2;
    end
    case (state_reg.state)
      ST_IDLE: begin
        if (state_reg.adapt_enable && coeff_wr_en) begin
          state_next.coeff[coeff_wr_idx] = coeff_wr_data;
        end
        if (out_rise) begin
          state_next.state = ST_EXPAND;
          state_next.busy = 1'b1;
          state_next.adapt_enable = 1'b0;
        end
      end
      ST_EXPAND: begin
        for (int k = LINE_LEN - 1; k > 0; k--) begin
          state_next.line[k] = state_reg.line[k-1];
        end
        state_next.line[0] = {{2{lin_value[13]}}, lin_value};
        state_next.ref_abs_sample = abs16({{2{lin_value[13]}}, lin_value});
        state_next.state = ST_HPF;
      end
      ST_HPF: begin
        state_next.nearend_raw_linear = {{2{lin_value[13]}}, lin_value};
        state_next.raw_prev = state_next.nearend_raw_linear;
        s40 = 40'(signed'({state_reg.nearend_filtered_msw,
                           state_reg.nearend_filtered_lsw}));
        d40 = 40'(signed'(state_next.nearend_raw_linear))
            - 40'(signed'(state_reg.raw_prev));
        // Gain and pole keep the result inside 32 bits for 14-bit inputs.
        w = s40 - (s40 >>> `VEC_HPF_SHIFT) + (d40 <<< `VEC_HALF_SHIFT)
          - (d40 <<< `VEC_HALFG_SHIFT);
        state_next.nearend_filtered_msw = w[31:16];
        state_next.nearend_filtered_lsw = w[15:0];
        state_next.acc = 40'h0;
        state_next.tap = 8'h00;
        state_next.state = ST_MAC;
      end
      ST_MAC: begin
        mac = signed'(state_reg.coeff[state_reg.tap[6:0]])
            * signed'(state_reg.line[state_reg.tap[6:0]]);
        state_next.acc = state_reg.acc + 40'(mac);
        state_next.tap = state_reg.tap + 8'h01;
        if (int'(state_reg.tap) == TAPS - 1) begin
          state_next.state = ST_ESTIMATE;
        end
      end
      ST_ESTIMATE: begin
        state_next.echo_estimate =
          sat16(signed'(state_reg.acc) >>> `VEC_ECHO_ESTIMATE_LSB);
        state_next.state = ST_OUTPUT;
      end
      ST_OUTPUT: begin
        u = sat16(40'(signed'(state_reg.nearend_filtered_msw))
                - 40'(signed'(state_reg.echo_estimate)));
        if (state_reg.hangover_counter == 10'h000 &&
            state_reg.output_mag_average <
            (state_reg.ref_mag_average >> `VEC_SUPP_SHIFT)) begin
          u = 16'h0000;
        end
        state_next.cancel_out = u;
        state_next.state = ST_COMPRESS;
      end
      ST_COMPRESS: begin
        state_next.tx_code = comp_code;
        state_next.tx_valid = 1'b1;
        state_next.state = ST_AVERAGE;
      end
      ST_AVERAGE: begin
        state_next.output_mag_average = avg_step(state_reg.output_mag_average,
          abs16(state_reg.cancel_out), 16'h0000);
        state_next.ref_mag_average = avg_step(state_reg.ref_mag_average,
          state_reg.ref_abs_sample, CUTOFF);
        state_next.rem = 17'h00000;
        state_next.recip = 16'h0000;
        state_next.bitcnt = `VEC_DIV_STEPS;
        state_next.state = ST_RECIP;
      end
      ST_RECIP: begin
        t = {state_reg.rem[15:0], num[state_reg.bitcnt[3:0]]};
        q = {state_reg.recip[14:0], 1'b0};
        if (t >= {1'b0, state_reg.ref_mag_average}) begin
          t = t - {1'b0, state_reg.ref_mag_average};
          q[0] = 1'b1;
        end
        state_next.rem = t;
        state_next.recip = q;
        state_next.bitcnt = state_reg.bitcnt - 5'h01;
        if (state_reg.bitcnt == 5'h00) begin
          if (q[15]) state_next.recip = `VEC_Q15_MAX;
          state_next.state = ST_NORM;
        end
      end
      ST_NORM: begin
        prod = signed'(state_reg.cancel_out) * signed'(state_reg.recip);
        for (int k = UN_LEN - 1; k > 0; k--) begin
          state_next.un_hist[k] = state_reg.un_hist[k-1];
        end
        state_next.un_hist[0] = sat16(40'(prod));
        state_next.state = ST_FINISH;
      end
      ST_FINISH: begin
        if (near_speech_detect) begin
          state_next.hangover_counter = HANG_LEN;
        end else if (state_reg.hangover_counter != 10'h000) begin
          state_next.hangover_counter = state_reg.hangover_counter - 10'h001;
        end
        state_next.adapt_enable =
          (state_next.hangover_counter == 10'h000);
        state_next.busy = 1'b0;
        state_next.state = ST_IDLE;
      end
      default: begin
        state_next.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.state <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tx_code                 = state_reg.tx_code;
  assign tx_valid                = state_reg.tx_valid;
  assign busy                    = state_reg.busy;
  assign adapt_enable            = state_reg.adapt_enable;
  assign ref_newest_sample       = state_reg.line[0];
  assign ref_abs_sample          = state_reg.ref_abs_sample;
  assign echo_estimate           = state_reg.echo_estimate;
  assign cancel_output           = state_reg.cancel_out;
  assign output_mag_average      = state_reg.output_mag_average;
  assign ref_mag_average         = state_reg.ref_mag_average;
  assign ref_average_reciprocal  = state_reg.recip;
  assign normalized_error_newest = state_reg.un_hist[0];
  assign hangover_counter        = state_reg.hangover_counter;
  assign hist_rd_data            = state_reg.hist_rd_data;
  assign ref_rd_data             = state_reg.ref_rd_data;
endmodule

/* File: test/vec_datapath_sva.sv */
// Purpose: Port-level checker for the echo canceller datapath.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every vec_datapath instance.
`timescale 1ns/1ps
module vec_datapath_chk #(
  parameter logic [9:0] HANG_LEN = 10'd600
) (
  input wire logic               ref_clk,
  input wire logic               reset,
  input wire logic               near_speech_detect,
  input wire logic [7:0]         ref_rd_idx,
  input wire vec_pkg::vec_code_t tx_code,
  input wire logic               tx_valid,
  input wire logic               busy,
  input wire logic               adapt_enable,
  input wire logic [15:0]        ref_newest_sample,
  input wire logic [15:0]        ref_abs_sample,
  input wire logic [15:0]        ref_mag_average,
  input wire logic [15:0]        ref_average_reciprocal,
  input wire logic [9:0]         hangover_counter,
  input wire logic [15:0]        ref_rd_data
);
  import vec_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_busy_to_tx: assert property ($rose(busy) |-> ##[120:140] tx_valid)
    else $error("no output within the sequence");
  a_tx_to_idle: assert property (tx_valid |-> ##[10:30] !busy)
    else $error("sequence did not end");
  a_tx_pulse: assert property (tx_valid |=> !tx_valid)
    else $error("output strobe too long");
  a_tx_hold: assert property (!tx_valid |-> $stable(tx_code))
    else $error("output code changed without strobe");
  a_adapt_busy: assert property (busy |-> !adapt_enable)
    else $error("adaptation enabled while busy");
  a_adapt_hang: assert property (adapt_enable |-> hangover_counter == 10'h0)
    else $error("adaptation enabled during hangover");
  a_hang_load: assert property ($fell(busy) && $past(near_speech_detect)
    |-> hangover_counter == HANG_LEN)
    else $error("hangover not loaded");
  a_hang_dec: assert property ($fell(busy) && !$past(near_speech_detect)
    |-> hangover_counter == ($past(hangover_counter) == 10'h0 ? 10'h0
    : $past(hangover_counter) - 10'h1))
    else $error("hangover did not count down");
  a_hang_hold: assert property (!$fell(busy) |-> $stable(hangover_counter))
    else $error("hangover changed mid sequence");
  a_rd_range: assert property (ref_rd_idx >= 8'd144 |=> ref_rd_data == 16'h0)
    else $error("line read beyond end not zero");
  a_recip_val: assert property (!busy && ref_mag_average > 16'h1
    |-> ref_average_reciprocal == 16'(32'h8000 / ref_mag_average))
    else $error("reciprocal wrong");
  a_abs_ref: assert property (!busy |-> ref_abs_sample == (ref_newest_sample[15]
    ? 16'h0 - ref_newest_sample : ref_newest_sample))
    else $error("reference magnitude wrong");
  c_tx: cover property (tx_valid);
  c_adapt: cover property (adapt_enable);
  c_hang: cover property (hangover_counter == HANG_LEN);
endmodule
bind vec_datapath vec_datapath_chk #(.HANG_LEN(HANG_LEN)) u_chk (
  .ref_clk(ref_clk), .reset(reset), .near_speech_detect(near_speech_detect),
  .ref_rd_idx(ref_rd_idx), .tx_code(tx_code), .tx_valid(tx_valid), .busy(busy),
  .adapt_enable(adapt_enable), .ref_newest_sample(ref_newest_sample),
  .ref_abs_sample(ref_abs_sample), .ref_mag_average(ref_mag_average),
  .ref_average_reciprocal(ref_average_reciprocal),
  .hangover_counter(hangover_counter), .ref_rd_data(ref_rd_data));

/* File: test/vec_pcm_model.sv */
// Purpose: Channel interface model giving codes and sample marks.
// Assumes: One request pulse per sample period.
// Notes: Codes are inverted once the capture window is over.
`timescale 1ns/1ps
module vec_pcm_model (
  input wire logic               ref_clk,
  input wire logic               go,
  input wire vec_pkg::vec_code_t ref_code_in,
  input wire vec_pkg::vec_code_t near_code_in,
  output logic                   out_mark,
  output logic                   in_mark,
  output vec_pkg::vec_code_t     ref_code_pin,
  output vec_pkg::vec_code_t     near_code_pin
);
  import vec_pkg::*;
  int cnt = 99;
  initial begin
    out_mark = 1'b0;
    in_mark = 1'b0;
    ref_code_pin = 8'h00;
    near_code_pin = 8'h00;
  end
  // Input mark first, output mark later in the same frame.
  always @(posedge ref_clk) begin
    cnt <= go ? 0 : (cnt < 99 ? cnt + 1 : cnt);
    in_mark <= #1 (cnt >= 1 && cnt < 5);
    out_mark <= #1 (cnt >= 12 && cnt < 16);
    if (cnt == 0) begin
      ref_code_pin <= #1 ref_code_in;
      near_code_pin <= #1 near_code_in;
    end else if (cnt == 9) begin
      ref_code_pin <= #1 ~ref_code_pin;
      near_code_pin <= #1 ~near_code_pin;
    end
  end
endmodule

/* File: test/vec_datapath_tb.sv */
// Purpose: Self-checking bench of the echo canceller datapath.
// Assumes: Mu-law build; near-end codes vary in the random stream.
// Notes: A reference model tracks line, taps and averages.
`timescale 1ns/1ps
`include "vec_defs.svh"
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, a); end end
module vec_datapath_tb;
  import vec_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic go = 1'b0;
  logic near_speech_detect = 1'b0;
  logic coeff_wr_en = 1'b0;
  logic [6:0] coeff_wr_idx = 7'h0;
  logic [15:0] coeff_wr_data = 16'h0;
  logic [3:0] hist_rd_idx = 4'h1;
  logic [7:0] ref_rd_idx = 8'h0;
  logic out_mark, in_mark, tx_valid, busy, adapt_enable;
  vec_code_t ref_code_pin, near_code_pin, tx_code;
  vec_code_t rc = 8'hff;
  vec_code_t nc = 8'hff;
  logic [15:0] ref_newest_sample, ref_abs_sample, echo_estimate, cancel_output;
  logic [15:0] output_mag_average, ref_mag_average, ref_average_reciprocal;
  logic [15:0] normalized_error_newest, hist_rd_data, ref_rd_data, seed;
  logic [9:0] hangover_counter;
  int fail_count = 0;
  int checks_done = 0;
  int line[144], coef[128];
  int ravg = 0, oavg = 0, hang = 0, un = 0, unp = 0;
  int xp = 0;
  longint sq = 0;
  always #20 ref_clk = ~ref_clk;
  vec_pcm_model pcm (.ref_clk(ref_clk), .go(go), .ref_code_in(rc), .near_code_in(nc),
    .out_mark(out_mark), .in_mark(in_mark), .ref_code_pin(ref_code_pin),
    .near_code_pin(near_code_pin));
  vec_datapath uut (.ref_clk(ref_clk), .reset(reset), .out_mark(out_mark),
    .in_mark(in_mark), .ref_code_pin(ref_code_pin), .near_code_pin(near_code_pin),
    .near_speech_detect(near_speech_detect), .coeff_wr_en(coeff_wr_en),
    .coeff_wr_idx(coeff_wr_idx), .coeff_wr_data(coeff_wr_data),
    .hist_rd_idx(hist_rd_idx), .ref_rd_idx(ref_rd_idx), .tx_code(tx_code),
    .tx_valid(tx_valid), .busy(busy), .adapt_enable(adapt_enable),
    .ref_newest_sample(ref_newest_sample), .ref_abs_sample(ref_abs_sample),
    .echo_estimate(echo_estimate), .cancel_output(cancel_output),
    .output_mag_average(output_mag_average), .ref_mag_average(ref_mag_average),
    .ref_average_reciprocal(ref_average_reciprocal),
    .normalized_error_newest(normalized_error_newest),
    .hangover_counter(hangover_counter), .hist_rd_data(hist_rd_data),
    .ref_rd_data(ref_rd_data));
  function automatic int expand(logic [7:0] c);
    logic [7:0] v;
    int m;
    v = ~c;
    m = ((((int'(v[3:0]) << 3) + 132) << v[6:4]) - 132) >>> 2;
    return v[7] ? -m : m;
  endfunction
  function automatic int sat(longint x);
    return x > 32767 ? 32767 : (x < -32768 ? -32768 : int'(x));
  endfunction
  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input int idx, input int d);
    @(posedge ref_clk);
    #1 coeff_wr_en = 1'b1;
    coeff_wr_idx = 7'(idx);
    coeff_wr_data = 16'(d);
    @(posedge ref_clk);
    #1 coeff_wr_en = 1'b0;
    if (hang == 0) coef[idx] = int'(signed'(16'(d)));
  endtask
  task automatic run_seq(input logic [7:0] code, input logic sp, input logic [7:0] ri,
                         input logic [7:0] nearc);
    int n, a, est, u, r, ns;
    longint acc;
    rc = code;
    nc = nearc;
    near_speech_detect = sp;
    ref_rd_idx = ri;
    go = 1'b1;
    @(posedge ref_clk);
    #1 go = 1'b0;
    n = 0;
    while (busy !== 1'b1 && n < 100) begin @(posedge ref_clk); #1 n++; end
    `CHK("busy rise", 1'b1, busy)
    n = 0;
    while (busy !== 1'b0 && n < 300) begin @(posedge ref_clk); #1 n++; end
    `CHK("busy fall", 1'b0, busy)
    repeat (2) @(posedge ref_clk);
    #1;
    for (int k = 143; k > 0; k--) line[k] = line[k-1];
    line[0] = expand(code);
    acc = 0;
    for (int k = 0; k < 128; k++) acc += longint'(coef[k]) * line[k];
    est = sat(acc >>> 15);
    ns = expand(nearc);
    sq = sq - (sq >>> 3) + longint'(ns - xp) * 28672;
    xp = ns;
    u = sat((sq >>> 16) - est);
    if (hang == 0 && oavg < (ravg >> 4)) u = 0;
    a = line[0] < 0 ? -line[0] : line[0];
    ravg = int'((longint'(ravg) * 65024 + 512 * (a + `VEC_CUTOFF)) >>> 16);
    oavg = int'((longint'(oavg) * 65024 + 512 * (u < 0 ? -u : u)) >>> 16);
    r = ravg < 2 ? 32767 : 32768 / ravg;
    unp = un;
    un = sat(longint'(u) * r);
    hang = sp ? 600 : (hang > 0 ? hang - 1 : 0);
    `CHK("newest", 16'(line[0]), ref_newest_sample)
    `CHK("abs", 16'(a), ref_abs_sample)
    `CHK("estimate", 16'(est), echo_estimate)
    `CHK("output", 16'(u), cancel_output)
    if (u == 0) `CHK("tx code", 8'hff, tx_code)
    `CHK("out avg", 16'(oavg), output_mag_average)
    `CHK("ref avg", 16'(ravg), ref_mag_average)
    `CHK("recip", 16'(r), ref_average_reciprocal)
    `CHK("norm", 16'(un), normalized_error_newest)
    `CHK("hangover", 10'(hang), hangover_counter)
    `CHK("history", 16'(unp), hist_rd_data)
    `CHK("line", ri < 144 ? 16'(line[ri]) : 16'h0, ref_rd_data)
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    $display("ERROR watchdog expired");
    report_and_stop;
  end
  initial begin
    seed = 16'h7;
    foreach (line[k]) line[k] = 0;
    foreach (coef[k]) coef[k] = 0;
    repeat (10) @(posedge ref_clk);
    #1 reset = 1'b0;
    ref_rd_idx = 8'd7;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("rst est", 16'h0, echo_estimate)
    `CHK("rst hang", 10'h0, hangover_counter)
    `CHK("rst adapt", 1'b0, adapt_enable)
    `CHK("rst line", 16'h0, ref_rd_data)
    $display("test reset done");
    run_seq(8'h80, 1'b0, 8'd0, 8'hff);
    run_seq(8'h00, 1'b0, 8'd1, 8'hff);
    wr(0, 16'h4000);
    wr(3, 16'h8000);
    for (int i = 0; i < 150; i++) begin
      seed = lfsr(seed);
      run_seq(seed[7:0], i == 2, i > 145 ? 8'(140 + i - 146) : seed[15:8],
              {seed[3:0], seed[15:12]});
      if (i == 5) wr(1, 16'h7fff);
    end
    $display("test stream done");
    report_and_stop;
  end
endmodule
